// >>> logic/sbe_engine.sv
// serial byte engine with wishbone registers and shared byte buffer
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Contract
// - receive full clears once software reads the programmed byte count
// - receive-only mode: interrupt when last bit of last byte arrives
// - external clock: byte finishing while buffer full sets receive error
// - halt write clears start bit, status, sequence and buffer pointers; byte count kept
// - internal clock starts at once; external shifts on pin pulses
// - count, bit order and clock source shared by both directions
// - drive on falling clock edge, sample on rising edge
// - halt stops the sequence at once, even mid-byte
// - full-duplex halt discards received bytes
// - full-duplex: interrupt when last bit of last byte received
// - external clock fall with empty tx buffer sets tx error; output high
// - mode field receive encoding selects receive-only mode
module sbe_engine (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// serial pins
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_o,
	input  wire logic        si_i,
	output logic             so_o,
	// event
	output logic             serial_done_irq_o
);
	localparam int START_MAX = sbe_pkg::SCK_HALF_CYC + 3;
	localparam logic [sbe_pkg::DIV_W-1:0] HALF_CNT =
		sbe_pkg::DIV_W'(sbe_pkg::SCK_HALF_CYC - 1);

	logic [sbe_pkg::BUF_DEPTH-1:0][7:0] buf_q;
	sbe_pkg::sbe_state_t                state_q;
	sbe_pkg::sbe_mode_t                 mode_q;
	logic                               start_q;
	logic                               dir_q;
	logic [2:0]                         clk_sel_q;
	logic [sbe_pkg::CNT_W-1:0]          cnt_q;
	logic                               rxf_q;
	logic                               transmit_error_flag_q;
	logic                               receive_error_flag_q;
	logic [sbe_pkg::IDX_W-1:0]          done_q;
	logic [sbe_pkg::IDX_W-1:0]          wr_ptr_q;
	logic [sbe_pkg::IDX_W-1:0]          rd_ptr_q;
	logic [sbe_pkg::DIV_W-1:0]          div_q;
	logic                               sck_int_q;
	logic                               so_q;
	logic                               irq_q;
	logic                               ack_q;
	logic [31:0]                        dat_q;
	logic [1:0]                         pin_lvl;
	logic [1:0]                         pin_prev;
	logic [sbe_pkg::IDX_W-1:0]          nbytes;
	logic                               ext;
	logic                               busy;
	logic                               transmit_empty_flag;
	logic                               rx_on;
	logic                               tx_on;
	logic                               req;
	logic                               wr_c1;
	logic                               halt_wr;
	logic                               wr_data;
	logic                               rd_data;
	logic                               int_go;
	logic                               int_tick;
	logic                               fall;
	logic                               rise;
	logic                               store;
	logic                               last_byte;
	logic                               final_rd;

	sbe_shift_if sh ();

	sbe_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({si_i, sck_i}),
		.level_o (pin_lvl),
		.prev_o  (pin_prev)
	);

	sbe_shifter u_shift (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.sh    (sh)
	);

	// bus decode
	assign req     = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_c1   = req && wb_we_i && wb_sel_i[0] && wb_adr_i == sbe_pkg::ADR_CTRL1;
	assign halt_wr = wr_c1 && wb_dat_i[sbe_pkg::C1_HALT];
	assign wr_data = req && wb_we_i && wb_sel_i[0] && wb_adr_i == sbe_pkg::ADR_DATA
		&& !busy && wr_ptr_q < sbe_pkg::IDX_W'(sbe_pkg::BUF_DEPTH);
	assign rd_data = req && !wb_we_i && wb_adr_i == sbe_pkg::ADR_DATA;

	// shared settings for both directions
	assign nbytes = {1'b0, cnt_q} + sbe_pkg::IDX_W'(1);
	assign ext    = clk_sel_q == sbe_pkg::CLK_EXT;
	assign busy   = state_q != sbe_pkg::SBE_IDLE;
	assign rx_on  = mode_q == sbe_pkg::SBE_MODE_RX || mode_q == sbe_pkg::SBE_MODE_TXRX;
	assign tx_on  = mode_q == sbe_pkg::SBE_MODE_TX || mode_q == sbe_pkg::SBE_MODE_TXRX;
	assign transmit_empty_flag    = done_q >= wr_ptr_q;

	// shift clock: internal divider or synchronised pin edges
	assign int_go = !ext && ((state_q == sbe_pkg::SBE_RUN && done_q < nbytes && !rxf_q)
		|| (state_q == sbe_pkg::SBE_STOP && sh.bit_cnt != 3'h0));
	assign int_tick = int_go && div_q == HALF_CNT;
	assign fall = busy && !halt_wr && (ext ? (pin_prev[0] && !pin_lvl[0])
		: (int_tick && sck_int_q));
	assign rise = busy && !halt_wr && (ext ? (!pin_prev[0] && pin_lvl[0])
		: (int_tick && !sck_int_q));

	assign sh.fall      = fall;
	assign sh.rise      = rise;
	assign sh.abort     = halt_wr;
	assign sh.msb_first = dir_q;
	assign sh.ser_in    = pin_lvl[1];
	assign sh.load_byte = buf_q[done_q[sbe_pkg::CNT_W-1:0]];

	assign store     = sh.byte_done && busy && !rxf_q;
	assign last_byte = store && done_q == nbytes - sbe_pkg::IDX_W'(1);
	assign final_rd  = rd_data && rd_ptr_q == nbytes - sbe_pkg::IDX_W'(1);

	always_ff @(posedge clk_i) begin
		if (rst_i || !int_go) begin
			div_q     <= '0;
			sck_int_q <= 1'b1;
		end else if (int_tick) begin
			div_q     <= '0;
			sck_int_q <= !sck_int_q;
		end else begin
			div_q <= div_q + sbe_pkg::DIV_W'(1);
		end
	end

	// wishbone answer, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i) begin
				unique case (wb_adr_i)
					sbe_pkg::ADR_CTRL1: dat_q <= {24'h00_0000, start_q, 1'b0,
						mode_q, dir_q, clk_sel_q};
					sbe_pkg::ADR_CTRL2: dat_q <= {27'h000_0000, cnt_q};
					sbe_pkg::ADR_STAT:  dat_q <= {24'h00_0000, busy,
						busy && sh.bit_cnt != 3'h0, rxf_q, transmit_empty_flag, transmit_error_flag_q, receive_error_flag_q, 2'h0};
					sbe_pkg::ADR_DATA:  dat_q <= {24'h00_0000,
						buf_q[rd_ptr_q[sbe_pkg::CNT_W-1:0]]};
					default:            dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_q   <= 1'b0;
			mode_q    <= sbe_pkg::SBE_MODE_TX;
			dir_q     <= 1'b0;
			clk_sel_q <= 3'h0;
			cnt_q     <= '0;
		end else begin
			if (wr_c1) begin
				start_q   <= wb_dat_i[sbe_pkg::C1_START] && !halt_wr;
				mode_q    <= sbe_pkg::sbe_mode_t'(wb_dat_i[sbe_pkg::C1_MODE_LO +: 2]);
				dir_q     <= wb_dat_i[sbe_pkg::C1_DIR];
				clk_sel_q <= wb_dat_i[sbe_pkg::C1_CLK_LO +: 3];
			end
			if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == sbe_pkg::ADR_CTRL2) begin
				cnt_q <= wb_dat_i[sbe_pkg::CNT_W-1:0];
			end
		end
	end

	// engine sequence
	always_ff @(posedge clk_i) begin
		if (rst_i || halt_wr) begin
			state_q <= sbe_pkg::SBE_IDLE;
		end else begin
			unique case (state_q)
				sbe_pkg::SBE_IDLE: if (start_q) state_q <= sbe_pkg::SBE_RUN;
				sbe_pkg::SBE_RUN:  if (!start_q) state_q <= sbe_pkg::SBE_STOP;
				sbe_pkg::SBE_STOP: begin
					if (sh.bit_cnt == 3'h0 && !rise) begin
						state_q <= sbe_pkg::SBE_IDLE;
					end
				end
				default:           state_q <= sbe_pkg::SBE_IDLE;
			endcase
		end
	end

	// byte counters and buffer pointers
	always_ff @(posedge clk_i) begin
		if (rst_i || halt_wr) begin
			done_q   <= '0;
			rd_ptr_q <= '0;
			wr_ptr_q <= '0;
		end else begin
			if (state_q == sbe_pkg::SBE_IDLE && start_q) begin
				done_q <= '0;
			end else if (store) begin
				done_q <= done_q + sbe_pkg::IDX_W'(1);
			end
			if (final_rd) begin
				rd_ptr_q <= '0;
				wr_ptr_q <= '0;
			end else begin
				if (rd_data) rd_ptr_q <= rd_ptr_q + sbe_pkg::IDX_W'(1);
				if (wr_data) begin
					wr_ptr_q <= wr_ptr_q + sbe_pkg::IDX_W'(1);
				end else if (state_q == sbe_pkg::SBE_STOP && mode_q == sbe_pkg::SBE_MODE_TX
					&& sh.bit_cnt == 3'h0 && !rise) begin
					wr_ptr_q <= '0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (store && rx_on) begin
			buf_q[done_q[sbe_pkg::CNT_W-1:0]] <= sh.rx_byte;
		end else if (wr_data) begin
			buf_q[wr_ptr_q[sbe_pkg::CNT_W-1:0]] <= wb_dat_i[7:0];
		end
	end

	// status flags: a set wins over a read clear in the same cycle, a halt wins over a set
	always_ff @(posedge clk_i) begin
		if (rst_i || halt_wr) begin
			rxf_q   <= 1'b0;
			transmit_error_flag_q <= 1'b0;
			receive_error_flag_q <= 1'b0;
		end else begin
			if (last_byte && rx_on) begin
				rxf_q <= 1'b1;
			end else if (final_rd) begin
				rxf_q <= 1'b0;
			end
			if (ext && sh.byte_done && busy && rx_on && rxf_q) begin
				receive_error_flag_q <= 1'b1;
			end
			if (ext && fall && tx_on && transmit_empty_flag && sh.bit_cnt == 3'h0) begin
				transmit_error_flag_q <= 1'b1;
			end
		end
	end

	// outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			so_q     <= 1'b1;
			irq_q    <= 1'b0;
			sck_oe_o <= 1'b0;
		end else begin
			so_q     <= (transmit_error_flag_q || receive_error_flag_q || !tx_on || !busy) ? 1'b1 : sh.ser_out;
			irq_q    <= last_byte && !halt_wr;
			sck_oe_o <= !ext;
		end
	end

	assign wb_ack_o          = ack_q;
	assign wb_dat_o          = dat_q;
	assign so_o              = so_q;
	assign sck_o             = sck_int_q;
	assign serial_done_irq_o = irq_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_rxf_read_clear: assert property (final_rd && !(last_byte && rx_on) |=> !rxf_q)
		else $error("receive full not cleared after final read");
	a_irq_last_rx: assert property (last_byte && !halt_wr |=> serial_done_irq_o
		##1 !serial_done_irq_o) else $error("done interrupt not a single pulse");
	a_irq_duplex: assert property ($rose(rxf_q) && mode_q == sbe_pkg::SBE_MODE_TXRX
		|-> serial_done_irq_o)
		else $error("no interrupt with duplex completion");
	a_receive_error_flag_on_full: assert property (ext && sh.byte_done && busy && rx_on && rxf_q
		&& !halt_wr |=> receive_error_flag_q) else $error("receive error not set");
	a_halt_clears: assert property (halt_wr |=> !start_q && !rxf_q && !transmit_error_flag_q
		&& !receive_error_flag_q && !busy) else $error("halt did not clear start and status");
	a_halt_keeps_cnt: assert property (halt_wr |=> $stable(cnt_q))
		else $error("halt changed byte count");
	a_halt_discard: assert property (halt_wr && mode_q == sbe_pkg::SBE_MODE_TXRX
		|=> rd_ptr_q == '0 && done_q == '0 && sh.bit_cnt == 3'h0)
		else $error("halt kept received data");
	a_int_starts: assert property (!busy && start_q && !ext && !halt_wr && cnt_q == $past(cnt_q)
		|-> ##[1:START_MAX] (!sck_int_q || !busy)) else $error("internal clock did not start");
	a_transmit_error_flag_so_high: assert property (transmit_error_flag_q || receive_error_flag_q |=> so_o)
		else $error("serial output not high on error");
	a_busy_stops: assert property (state_q == sbe_pkg::SBE_STOP && sh.bit_cnt == 3'h0
		&& !rise |=> !busy) else $error("busy not cleared after stop");
endmodule : sbe_engine

// >>> logic/sbe_pkg.sv
// constants and types shared by the serial byte engine
package sbe_pkg;
	// register byte addresses
	localparam logic [3:0] ADR_CTRL1 = 4'h0;
	localparam logic [3:0] ADR_CTRL2 = 4'h4;
	localparam logic [3:0] ADR_STAT  = 4'h8;
	localparam logic [3:0] ADR_DATA  = 4'hc;
	// serial_control_one fields
	localparam int C1_START   = 7;
	localparam int C1_HALT    = 6;
	localparam int C1_MODE_LO = 4;
	localparam int C1_DIR     = 3;
	localparam int C1_CLK_LO  = 0;
	localparam logic [2:0] CLK_EXT = 3'h7;
	// serial_status_reg fields
	localparam int ST_BUSY  = 7;
	localparam int ST_SHIFT = 6;
	localparam int ST_RXF   = 5;
	localparam int ST_TXF   = 4;
	localparam int ST_TRANSMIT_ERROR_FLAG = 3;
	localparam int ST_RECEIVE_ERROR_FLAG = 2;
	// buffer and counters
	localparam int BUF_DEPTH = 32;
	localparam int CNT_W     = 5;
	localparam int IDX_W     = 6;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// internal shift clock half period
	localparam int CLK_NS       = 10;
	localparam int SCK_HALF_NS  = 500;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_W        = 8;
	typedef enum logic [1:0] {
		SBE_MODE_TX   = 2'b00,
		SBE_MODE_RX   = 2'b01,
		SBE_MODE_TXRX = 2'b10,
		SBE_MODE_RSVD = 2'b11
	} sbe_mode_t;
	typedef enum logic [1:0] {
		SBE_IDLE = 2'b00,
		SBE_RUN  = 2'b01,
		SBE_STOP = 2'b10
	} sbe_state_t;
endpackage : sbe_pkg

// >>> logic/sbe_shift_if.sv
// link between the engine control and its bit shifter
`timescale 1ns/1ps
interface sbe_shift_if;
	logic       fall;
	logic       rise;
	logic       abort;
	logic       msb_first;
	logic [7:0] load_byte;
	logic       ser_in;
	logic       ser_out;
	logic [2:0] bit_cnt;
	logic       byte_done;
	logic [7:0] rx_byte;
	modport ctrl  (output fall, rise, abort, msb_first, load_byte, ser_in,
		input ser_out, bit_cnt, byte_done, rx_byte);
	modport shift (input fall, rise, abort, msb_first, load_byte, ser_in,
		output ser_out, bit_cnt, byte_done, rx_byte);
endinterface : sbe_shift_if

// >>> logic/sbe_shifter.sv
// byte shifter: drive on falling edge, sample on rising edge
`timescale 1ns/1ps
module sbe_shifter (
	// clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	// control side
	sbe_shift_if.shift sh
);
	logic [7:0] tx_q;
	logic [7:0] rx_q;

	function automatic logic first_bit(input logic [7:0] b, input logic msb);
		first_bit = msb ? b[7] : b[0];
	endfunction : first_bit

	function automatic logic [7:0] shift_on(input logic [7:0] b, input logic msb,
		input logic in);
		shift_on = msb ? {b[6:0], in} : {in, b[7:1]};
	endfunction : shift_on

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_q       <= 8'h00;
			sh.ser_out <= 1'b1;
		end else if (sh.fall && !sh.abort) begin
			if (sh.bit_cnt == 3'h0) begin
				sh.ser_out <= first_bit(sh.load_byte, sh.msb_first);
				tx_q       <= shift_on(sh.load_byte, sh.msb_first, 1'b0);
			end else begin
				sh.ser_out <= first_bit(tx_q, sh.msb_first);
				tx_q       <= shift_on(tx_q, sh.msb_first, 1'b0);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || sh.abort) begin
			rx_q         <= 8'h00;
			sh.bit_cnt   <= 3'h0;
			sh.byte_done <= 1'b0;
			sh.rx_byte   <= 8'h00;
		end else begin
			sh.byte_done <= 1'b0;
			if (sh.rise) begin
				rx_q       <= shift_on(rx_q, sh.msb_first, sh.ser_in);
				sh.bit_cnt <= sh.bit_cnt + 3'h1;
				if (sh.bit_cnt == sbe_pkg::BIT_LAST) begin
					sh.byte_done <= 1'b1;
					sh.rx_byte   <= shift_on(rx_q, sh.msb_first, sh.ser_in);
				end
			end
		end
	end
endmodule : sbe_shifter

// >>> logic/sbe_sync.sv
// two-stage synchroniser with a third stage for edge finding
`timescale 1ns/1ps
module sbe_sync (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// raw and synchronised levels
	input  wire logic [1:0] async_i,
	output logic      [1:0] level_o,
	output logic      [1:0] prev_o
);
	logic [1:0] meta_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q  <= 2'h3;
			level_o <= 2'h3;
			prev_o  <= 2'h3;
		end else begin
			meta_q  <= async_i;
			level_o <= meta_q;
			prev_o  <= level_o;
		end
	end
endmodule : sbe_sync

// >>> tb/sbe_far_dev.sv
// far-side serial device model sharing the shift clock line
`timescale 1ns/1ps
module sbe_far_dev (
	// shift clock level on the wire and data from the engine
	input  wire logic sck_w_i,
	input  wire logic so_i,
	// clock and data driven toward the engine
	output logic      sck_o,
	output logic      si_o
);
	logic [7:0] send_b [0:7];
	logic [7:0] got_b  [0:7];
	logic       msb_first;
	int         fall_n;
	int         rise_n;

	initial begin
		sck_o     = 1'b1;
		si_o      = 1'b1;
		msb_first = 1'b1;
		fall_n    = 0;
		rise_n    = 0;
	end

	// next bit out on each falling edge
	always @(negedge sck_w_i) begin
		si_o   <= send_b[(fall_n / 8) % 8][msb_first ? 7 - fall_n % 8 : fall_n % 8];
		fall_n <= fall_n + 1;
	end

	// engine bit taken on each rising edge
	always @(posedge sck_w_i) begin
		got_b[(rise_n / 8) % 8][msb_first ? 7 - rise_n % 8 : rise_n % 8] <= so_i;
		rise_n <= rise_n + 1;
	end

	// clock runs only inside a frame, idles high between frames
	task automatic frame(input int n);
		repeat (n) begin
			#62.5 sck_o = 1'b0;
			#62.5 sck_o = 1'b1;
		end
	endtask : frame

	// new frame: restart bit counts, data line no longer holds last bit
	task automatic clear(input logic msb);
		fall_n    = 0;
		rise_n    = 0;
		msb_first = msb;
		si_o      = ~si_o;
	endtask : clear
endmodule : sbe_far_dev

// >>> tb/test_sync_serial_rx_txrx_engine.sv
// self-checking bench for the serial byte engine
`timescale 1ns/1ps
module test_sync_serial_rx_txrx_engine;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [3:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        sck_i;
	logic        sck_o;
	logic        sck_oe_o;
	logic        si_i;
	logic        so_o;
	logic        irq_o;
	logic        ext_sck;
	logic [7:0]  q;
	int          err_count = 0;
	int          n_tests   = 0;
	int          irq_n     = 0;

	assign sck_i = sck_oe_o ? sck_o : ext_sck;

	sbe_engine i_sbe_engine (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_i),
		.sck_o(sck_o), .sck_oe_o(sck_oe_o), .si_i(si_i), .so_o(so_o),
		.serial_done_irq_o(irq_o));
	sbe_far_dev i_sbe_far_dev (.sck_w_i(sck_i), .so_i(so_o), .sck_o(ext_sck), .si_o(si_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) if (irq_o === 1'b1) irq_n <= irq_n + 1;

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one classic wishbone cycle, entered just after a rising edge
	task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o[7:0];
		if (n >= 50) err_count++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rd

	task automatic st(input int b, input logic v);
		wb(1'b0, sbe_pkg::ADR_STAT, 8'h00);
		chk({7'h0, q[b]}, {7'h0, v});
	endtask : st

	// external frame, then time for the pin synchroniser to settle
	task automatic pulse(input int n);
		i_sbe_far_dev.frame(n);
		repeat (10) @(posedge clk_i);
	endtask : pulse

	task automatic wait_irq(input int k);
		int n;
		n = 0;
		while (irq_n < k && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		chk(8'(irq_n), 8'(k));
	endtask : wait_irq

	initial begin
		rst_i    = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(sbe_pkg::ADR_STAT, 8'h10);
		rd(4'h1, 8'h00);
		chk({6'h0, sck_oe_o, so_o}, 8'h03);
		$display("test reset done");
		// full duplex, external clock, msb first, two bytes
		i_sbe_far_dev.clear(1'b1);
		i_sbe_far_dev.send_b[0] = 8'hc3;
		i_sbe_far_dev.send_b[1] = 8'h5a;
		wr(sbe_pkg::ADR_CTRL1, 8'h2f);
		wr(sbe_pkg::ADR_CTRL2, 8'h01);
		wr(sbe_pkg::ADR_DATA, 8'ha5);
		wr(sbe_pkg::ADR_DATA, 8'h3c);
		wr(sbe_pkg::ADR_CTRL1, 8'haf);
		st(sbe_pkg::ST_BUSY, 1'b1);
		pulse(16);
		wait_irq(1);
		chk(i_sbe_far_dev.got_b[0], 8'ha5);
		chk(i_sbe_far_dev.got_b[1], 8'h3c);
		st(sbe_pkg::ST_RXF, 1'b1);
		wr(sbe_pkg::ADR_CTRL1, 8'h2f);
		rd(sbe_pkg::ADR_DATA, 8'hc3);
		rd(sbe_pkg::ADR_DATA, 8'h5a);
		st(sbe_pkg::ST_RXF, 1'b0);
		st(sbe_pkg::ST_BUSY, 1'b0);
		$display("test full duplex done");
		// receive only, internal clock, lsb first, one byte
		i_sbe_far_dev.clear(1'b0);
		i_sbe_far_dev.send_b[0] = 8'h96;
		wr(sbe_pkg::ADR_CTRL1, 8'h10);
		wr(sbe_pkg::ADR_CTRL2, 8'h00);
		st(sbe_pkg::ST_RECEIVE_ERROR_FLAG, 1'b0);
		wr(sbe_pkg::ADR_CTRL1, 8'h90);
		chk({7'h0, sck_oe_o}, 8'h01);
		wait_irq(2);
		chk({7'h0, so_o}, 8'h01);
		wr(sbe_pkg::ADR_CTRL1, 8'h10);
		rd(sbe_pkg::ADR_DATA, 8'h96);
		st(sbe_pkg::ST_BUSY, 1'b0);
		$display("test receive only done");
		// receive error needs a whole extra byte of pulses
		i_sbe_far_dev.clear(1'b1);
		wr(sbe_pkg::ADR_CTRL1, 8'h1f);
		wr(sbe_pkg::ADR_CTRL1, 8'h9f);
		pulse(8);
		pulse(7);
		st(sbe_pkg::ST_RECEIVE_ERROR_FLAG, 1'b0);
		pulse(1);
		st(sbe_pkg::ST_RECEIVE_ERROR_FLAG, 1'b1);
		wr(sbe_pkg::ADR_CTRL1, 8'h5f);
		rd(sbe_pkg::ADR_STAT, 8'h10);
		rd(sbe_pkg::ADR_CTRL1, 8'h1f);
		$display("test receive error done");
		// halt in mid byte of a full duplex transfer
		i_sbe_far_dev.clear(1'b0);
		wr(sbe_pkg::ADR_CTRL1, 8'h27);
		wr(sbe_pkg::ADR_CTRL2, 8'h03);
		for (int i = 0; i < 4; i++)
			wr(sbe_pkg::ADR_DATA, 8'(8'h11 * i));
		wr(sbe_pkg::ADR_CTRL1, 8'ha7);
		pulse(3);
		st(sbe_pkg::ST_SHIFT, 1'b1);
		wr(sbe_pkg::ADR_CTRL1, 8'h67);
		rd(sbe_pkg::ADR_STAT, 8'h10);
		rd(sbe_pkg::ADR_CTRL2, 8'h03);
		pulse(2);
		chk({7'h0, so_o}, 8'h01);
		$display("test halt done");
		// clock fall with nothing left to send
		i_sbe_far_dev.clear(1'b0);
		wr(sbe_pkg::ADR_CTRL2, 8'h00);
		wr(sbe_pkg::ADR_DATA, 8'h81);
		wr(sbe_pkg::ADR_CTRL1, 8'ha7);
		pulse(9);
		st(sbe_pkg::ST_TRANSMIT_ERROR_FLAG, 1'b1);
		chk({7'h0, so_o}, 8'h01);
		chk(i_sbe_far_dev.got_b[0], 8'h81);
		wr(sbe_pkg::ADR_CTRL1, 8'h67);
		rd(sbe_pkg::ADR_STAT, 8'h10);
		$display("test transmit error done");
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("watchdog expired");
		end_sim();
	end
endmodule : test_sync_serial_rx_txrx_engine
